/* File: design/flash_cycle.sv */
// One flash bus cycle: address setup, strobe pulse, release with data hold.
// Assumes the sequencer starts it only while it reports not busy.
`timescale 1ns/10ps
`default_nettype none
module flash_cycle
  import flash_host_pkg::*;
(
  // Clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_NRST,
  // Request
  input  wire logic              i_start,
  input  wire logic              i_wr,
  input  wire logic              i_hv,
  input  wire logic [18:0]       i_addr,
  input  wire logic              i_am1,
  input  wire logic [DQ_W-1:0]   i_wdata,
  output logic                   o_busy,
  output logic                   o_done,
  output logic [DQ_W-1:0]        o_rdata,
  // Flash pins
  input  wire logic [DQ_W-1:0]   i_dq,
  output logic [DQ_W-1:0]        o_dq,
  output logic                   o_dq_oe,
  output logic [18:0]            o_addr,
  output logic                   o_am1,
  output logic                   o_ce_n,
  output logic                   o_oe_n,
  output logic                   o_we_n,
  output logic                   o_idv_hv
);

  cyc_t q, d;  // Engine state and its next value

  // Next state of the cycle engine
  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    case (q.st)
      CY_IDLE:
        if (i_start)
        begin
          d.st    = CY_SETUP;
          d.wr    = i_wr;
          d.hv    = i_hv;
          d.addr  = i_addr;
          d.am1   = i_am1;
          d.dq    = i_wdata;
          d.dq_oe = i_wr;
        end
      CY_SETUP:
      begin
        // Address settled; both strobes fall together, so it is stable at the later edge
        d.st   = CY_STROBE;  // R13
        d.ce_n = 1'b0;
        d.we_n = ~q.wr;      // R10
        d.oe_n = q.wr;       // R10
        d.cnt  = q.wr ? WP_CYC - 2'h1 : ACC_CYC - 2'h1;  // R9
      end
      CY_STROBE:
        if (q.cnt == 2'h0)
        begin
          // Both strobes rise together while data is still driven
          d.st   = CY_HOLD;  // R14
          d.ce_n = 1'b1;
          d.we_n = 1'b1;
          d.oe_n = 1'b1;
          if (!q.wr)
            d.rdata = i_dq;
        end
        else
          d.cnt = q.cnt - 2'h1;
      CY_HOLD:
      begin
        // Release the data bus and the elevated level
        d.st    = CY_IDLE;
        d.dq_oe = 1'b0;
        d.hv    = 1'b0;
        d.done  = 1'b1;
      end
      default:
        d.st = CY_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      q <= '{st: CY_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    else
      q <= d;
  end

  // Outputs straight from the state
  assign o_busy  = (q.st != CY_IDLE);
  assign o_done  = q.done;
  assign o_rdata = q.rdata;
  assign o_dq    = q.dq;
  assign o_dq_oe = q.dq_oe;
  assign o_addr  = q.addr;
  assign o_am1   = q.am1;
  assign o_ce_n  = q.ce_n;
  assign o_oe_n  = q.oe_n;
  assign o_we_n  = q.we_n;
  assign o_idv_hv = q.hv;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_we_pulse;
    $fell(o_we_n) ##1 !o_we_n;
  endsequence

  chk_write_oe_high: assert property (!o_we_n |-> o_oe_n && !o_ce_n)  // R10
    else $error("write strobe low without chip select or with output enable");
  chk_pulse_width: assert property ($fell(o_ce_n) |-> !o_ce_n [*2])  // R9
    else $error("strobe pulse shorter than two clocks");
  chk_addr_stable: assert property (s_we_pulse |-> $stable(o_addr))  // R13
    else $error("address moved during write strobe");
  chk_data_hold: assert property ($rose(o_we_n) |-> o_dq_oe && $stable(o_dq))  // R14
    else $error("write data released before strobe rise");
  chk_hv_read_only: assert property (o_idv_hv |-> o_we_n)  // R1
    else $error("write strobe during elevated identifier level");

endmodule : flash_cycle
`default_nettype wire

/* File: design/flash_host.sv */
// Host controller for a parallel NOR flash: APB registers, command sequences, identifier reads.
// Assumes APB on the same clock; elevated levels are made by external switches on its request.
//
// Notes on behaviour
// R1 - Elevated id-pin level identifier read only
// R2 - Code selects low, lowest or second high
// R3 - Sector on upper bits, 00h unprotected
// R4 - Device drives identifier on low byte
// R5 - Identifier also reachable by command sequence
// R6 - Protected sectors refuse program and erase
// R7 - Elevated reset level unprotects sectors temporarily
// R8 - Low supply locks out all writes
// R9 - Strobe pulses shorter than 5 ns ignored
// R10 - Write needs select, write low, output high
// R11 - Power-up write strobe gives no command
// R12 - Bad sequence returns flash to array read
// R13 - Address latched at later falling strobe
// R14 - Data latched at earlier rising strobe
// R15 - Array read after power-up and algorithms
// R16 - Suspended sectors read status in suspend
// R17 - Reset command before array read after timeout/identifier
// R18 - Reset command returns array read, address ignored
// R19 - Reset aborts erase sequence before erasing
// R20 - Reset aborts program sequence before programming
// R21 - Only reset leaves identifier mode
// R22 - Reset after timeout bit returns array read
// R23 - Command identifier offsets per word/byte mode
// R24 - Reset pin low returns array read
// R25 - Commands ignored while programming runs
// R26 - Elevated levels and lockout come from detectors
`timescale 1ns/10ps
`default_nettype none
module flash_host
  import flash_host_pkg::*;
#(
  parameter logic [ADDR_W-1:0] UNL_ADR1_W = 20'h00555,  // First unlock address, word mode
  parameter logic [ADDR_W-1:0] UNL_ADR2_W = 20'h002AA,  // Second unlock address, word mode
  parameter logic [ADDR_W-1:0] UNL_ADR1_B = 20'h00AAA,  // First unlock address, byte mode
  parameter logic [ADDR_W-1:0] UNL_ADR2_B = 20'h00555,  // Second unlock address, byte mode
  parameter logic [DQ_W-1:0]   UNL_D1     = 16'h00AA,   // First unlock data
  parameter logic [DQ_W-1:0]   UNL_D2     = 16'h0055,   // Second unlock data
  parameter logic [DQ_W-1:0]   CMD_ID     = 16'h0090,   // Identifier command data
  parameter logic [DQ_W-1:0]   CMD_RST    = 16'h00F0    // Reset command data
)(
  // Clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_NRST,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Flash pins
  input  wire logic [DQ_W-1:0]   I_FL_DQ,
  output logic [DQ_W-1:0]        O_FL_DQ,
  output logic                   O_FL_DQ_OE,
  output logic [18:0]            O_FL_ADDR,
  output logic                   O_FL_AM1,
  output logic                   O_FL_CE_N,
  output logic                   O_FL_OE_N,
  output logic                   O_FL_WE_N,
  output logic                   O_FL_BYTE_N,
  output logic                   O_FL_RESET_N,
  // Elevated level switch requests
  output logic                   O_FL_IDV_HV,
  output logic                   O_FL_RST_HV
);

  seq_t q, d;                       // Sequencer state and its next value
  logic              cyc_start;     // Start one bus cycle
  logic              cyc_wr;        // Cycle is a write
  logic              cyc_hv;        // Cycle uses elevated id-pin level
  logic [ADDR_W-1:0] cyc_la;        // Logical cycle address
  logic [18:0]       cyc_pa;        // Cycle address on the pins
  logic [DQ_W-1:0]   cyc_wd;        // Cycle write data
  logic              cyc_busy;      // Engine busy
  logic              cyc_done;      // Engine finished a cycle
  logic [DQ_W-1:0]   cyc_rd;        // Engine read data
  logic              apb_wr;        // APB write access phase
  logic              apb_setup;     // APB setup phase
  logic              go_req;        // Software start request
  logic              last_step;     // Final cycle of the operation
  logic [7:0]        id_ofs;        // Command identifier offset

  assign apb_wr    = PSEL && PENABLE && PWRITE;
  assign apb_setup = PSEL && !PENABLE;
  assign go_req    = apb_wr && (PADDR == REG_CTRL) && PWDATA[CTRL_GO_BIT];
  assign last_step = (q.op != OP_AUTOSEL) || (q.step == 2'h2);

  // Offset of the identifier word for command mode
  always_comb
  begin
    case (q.sel)
      SEL_DEVICE:  id_ofs = q.byte_mode ? ID_OFS_DEV_BYTE : ID_OFS_DEV_WORD;  // R23
      SEL_PROTECT: id_ofs = q.byte_mode ? ID_OFS_PRT_BYTE : ID_OFS_PRT_WORD;  // R23
      default:     id_ofs = ID_OFS_MAKER;                                     // R23
    endcase
  end

  // Address, data and direction of the current cycle
  always_comb
  begin
    cyc_wr = 1'b1;
    cyc_hv = 1'b0;
    cyc_la = q.addr;
    cyc_wd = q.wdata;
    case (q.op)
      OP_READ, OP_POLL:
        cyc_wr = 1'b0;
      OP_HVID:
      begin
        cyc_wr = 1'b0;  // R1
        cyc_hv = 1'b1;  // R1
      end
      OP_IDREAD:
      begin
        cyc_wr = 1'b0;
        cyc_la = {q.addr[ADDR_W-1:8], id_ofs};  // R3
      end
      OP_RESET:
        cyc_wd = CMD_RST;  // R18
      OP_AUTOSEL:
        case (q.step)
          2'h0:
          begin
            cyc_la = q.byte_mode ? UNL_ADR1_B : UNL_ADR1_W;  // R5
            cyc_wd = UNL_D1;
          end
          2'h1:
          begin
            cyc_la = q.byte_mode ? UNL_ADR2_B : UNL_ADR2_W;  // R5
            cyc_wd = UNL_D2;
          end
          default:
          begin
            cyc_la = q.byte_mode ? UNL_ADR1_B : UNL_ADR1_W;  // R5
            cyc_wd = CMD_ID;
          end
        endcase
      default:
        cyc_wr = 1'b1;
    endcase
    // Byte mode puts the lowest address bit on the extra pin
    cyc_pa = q.byte_mode ? cyc_la[ADDR_W-1:1] : cyc_la[18:0];
    if (cyc_hv)
    begin
      cyc_pa[6]   = 1'b0;     // R2
      cyc_pa[1:0] = q.sel;    // R2
    end
  end

  // Sequencer and registers
  always_comb
  begin
    d = q;
    // Register writes take effect in the access phase
    if (apb_wr)
      case (PADDR)
        REG_CTRL:
        begin
          d.byte_mode = PWDATA[CTRL_BYTE_BIT];
          d.unprot    = PWDATA[CTRL_UNPROT_BIT];  // R7
          d.hwrst     = PWDATA[CTRL_HWRST_BIT];   // R24
        end
        REG_ADDR:  d.addr  = PWDATA[ADDR_W-1:0];
        REG_WDATA: d.wdata = PWDATA[DQ_W-1:0];
        default:   d.addr  = q.addr;
      endcase
    // Read data and error answer are prepared in the setup phase
    if (apb_setup)
    begin
      d.pslverr = 1'b0;
      case (PADDR)
        REG_CTRL:   d.prdata = {23'h0, q.hwrst, 1'b0, q.unprot, q.byte_mode, q.sel, q.op};
        REG_ADDR:   d.prdata = {12'h0, q.addr};
        REG_WDATA:  d.prdata = {16'h0, q.wdata};
        REG_RDATA:  d.prdata = {16'h0, q.rdata};
        REG_STATUS: d.prdata = {27'h0, q.tmo, q.prot, q.refused, q.need_rst,
                                (q.st != ST_IDLE)};
        default:
        begin
          d.prdata  = 32'h0;
          d.pslverr = 1'b1;
        end
      endcase
    end
    case (q.st)
      ST_IDLE:
        if (go_req)
        begin
          d.op      = op_t'(PWDATA[CTRL_OP_LSB +: 3]);
          d.sel     = id_sel_t'(PWDATA[CTRL_SEL_LSB +: 2]);
          d.step    = 2'h0;
          // Array read before a reset command would return stale mode data
          if (op_t'(PWDATA[CTRL_OP_LSB +: 3]) == OP_READ && q.need_rst)
            d.refused = 1'b1;  // R17
          else
          begin
            d.refused = 1'b0;
            d.st      = ST_ISSUE;
          end
        end
      ST_ISSUE:
        d.st = ST_WAIT;
      ST_WAIT:
        if (cyc_done)
        begin
          if (!cyc_wr)
            d.rdata = cyc_rd;
          if (!last_step)
          begin
            d.step = q.step + 2'h1;
            d.st   = ST_ISSUE;
          end
          else
          begin
            d.st = ST_IDLE;
            if (q.op == OP_RESET)
              d.need_rst = 1'b0;  // R21
            if (q.op == OP_AUTOSEL)
              d.need_rst = 1'b1;  // R21
            if (q.op == OP_POLL)
              d.tmo = cyc_rd[TIMEOUT_STATUS_BIT];
            if (q.op == OP_POLL && cyc_rd[TIMEOUT_STATUS_BIT])
              d.need_rst = 1'b1;  // R22
            if ((q.op == OP_HVID || q.op == OP_IDREAD) && q.sel == SEL_PROTECT)
              d.prot = (cyc_rd[7:0] == PROT_CODE);  // R3
          end
        end
      default:
        d.st = ST_IDLE;
    endcase
    // A hardware reset pulse returns the flash to array read
    if (q.hwrst)
      d.need_rst = 1'b0;  // R24
  end

  // State register
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      q <= '{st: ST_IDLE, op: OP_READ, sel: SEL_MAKER, default: '0};
    else
      q <= d;
  end

  assign cyc_start = (q.st == ST_ISSUE);

  // Bus cycle engine
  flash_cycle u_cycle (
    .I_CLK   (I_CLK),
    .I_NRST  (I_NRST),
    .i_start (cyc_start),
    .i_wr    (cyc_wr),
    .i_hv    (cyc_hv),
    .i_addr  (cyc_pa),
    .i_am1   (q.byte_mode & cyc_la[0]),
    .i_wdata (cyc_wd),
    .o_busy  (cyc_busy),
    .o_done  (cyc_done),
    .o_rdata (cyc_rd),
    .i_dq    (I_FL_DQ),
    .o_dq    (O_FL_DQ),
    .o_dq_oe (O_FL_DQ_OE),
    .o_addr  (O_FL_ADDR),
    .o_am1   (O_FL_AM1),
    .o_ce_n  (O_FL_CE_N),
    .o_oe_n  (O_FL_OE_N),
    .o_we_n  (O_FL_WE_N),
    .o_idv_hv (O_FL_IDV_HV)
  );

  // Outputs
  assign PRDATA       = q.prdata;
  assign PSLVERR      = q.pslverr;
  assign PREADY       = 1'b1;
  assign O_FL_BYTE_N  = ~q.byte_mode;
  assign O_FL_RESET_N = ~q.hwrst;
  assign O_FL_RST_HV  = q.unprot;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_op_end(op_t o);
    q.st == ST_WAIT && cyc_done && last_step && q.op == o;
  endsequence

  chk_read_refused: assert property (q.st == ST_IDLE && go_req && q.need_rst &&  // R17
      PWDATA[2:0] == 3'h0 |=> q.refused && q.st == ST_IDLE && !cyc_busy [*2])
    else $error("array read issued while reset command pending");
  chk_autosel_mode: assert property (s_op_end(OP_AUTOSEL) ##0 !q.hwrst |=> q.need_rst)  // R21
    else $error("identifier entry did not mark reset needed");
  chk_reset_exit: assert property (s_op_end(OP_RESET) ##0 !q.hwrst |=> !q.need_rst)  // R21
    else $error("reset command did not clear identifier mode");
  chk_hv_code_sel: assert property (O_FL_IDV_HV && !O_FL_CE_N |->  // R2
      !O_FL_ADDR[6] && O_FL_ADDR[1:0] == q.sel && q.op == OP_HVID)
    else $error("code select pins wrong during elevated identifier read");
  chk_reset_data: assert property (q.op == OP_RESET && !O_FL_WE_N |->  // R18
      O_FL_DQ == CMD_RST)
    else $error("reset command data wrong");

endmodule : flash_host
`default_nettype wire

/* File: design/flash_host_pkg.sv */
// Constants, types and register map of the parallel NOR flash host controller.
// Assumes a 25 MHz system clock and an APB master that reaches the control registers.
package flash_host_pkg;

  // Clock and strobe timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_WP_NS       = 80;   // Write strobe low time
  localparam int T_ACC_NS      = 120;  // Read strobe low time before sampling
  localparam int T_GLITCH_NS   = 5;    // Shortest strobe the flash takes as a cycle
  localparam logic [1:0] WP_CYC  = 2'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] ACC_CYC = 2'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // Control register fields
  localparam int CTRL_OP_LSB     = 0;
  localparam int CTRL_SEL_LSB    = 3;
  localparam int CTRL_BYTE_BIT   = 5;
  localparam int CTRL_UNPROT_BIT = 6;
  localparam int CTRL_GO_BIT     = 7;
  localparam int CTRL_HWRST_BIT  = 8;

  // Status register fields
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_NEEDRST_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_PROT_BIT    = 3;
  localparam int STAT_TMO_BIT     = 4;

  // Flash geometry and identifier read offsets
  localparam int ADDR_W = 20;
  localparam int DQ_W   = 16;
  localparam int TIMEOUT_STATUS_BIT = 5;
  localparam logic [7:0] ID_OFS_MAKER    = 8'h00;
  localparam logic [7:0] ID_OFS_DEV_WORD = 8'h01;
  localparam logic [7:0] ID_OFS_DEV_BYTE = 8'h02;
  localparam logic [7:0] ID_OFS_PRT_WORD = 8'h02;
  localparam logic [7:0] ID_OFS_PRT_BYTE = 8'h04;
  localparam logic [7:0] PROT_CODE       = 8'h01;
  localparam logic [3:0] RESET_CTRL      = 4'h0;

  // Operations started through the control register
  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_WRITE   = 3'h1,
    OP_HVID    = 3'h2,
    OP_RESET   = 3'h3,
    OP_AUTOSEL = 3'h4,
    OP_IDREAD  = 3'h5,
    OP_POLL    = 3'h6
  } op_t;

  // Identifier selection
  typedef enum logic [1:0] {
    SEL_MAKER   = 2'h0,
    SEL_DEVICE  = 2'h1,
    SEL_PROTECT = 2'h2
  } id_sel_t;

  typedef enum logic [1:0] {
    CY_IDLE   = 2'h0,
    CY_SETUP  = 2'h1,
    CY_STROBE = 2'h2,
    CY_HOLD   = 2'h3
  } cyc_st_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ISSUE = 2'h1,
    ST_WAIT  = 2'h2
  } seq_st_t;

  // Bus cycle engine state
  typedef struct packed {
    cyc_st_t           st;
    logic [1:0]        cnt;
    logic              wr;
    logic              hv;
    logic [18:0]       addr;
    logic              am1;
    logic [DQ_W-1:0]   dq;
    logic              dq_oe;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [DQ_W-1:0]   rdata;
    logic              done;
  } cyc_t;

  // Sequencer and register state
  typedef struct packed {
    seq_st_t           st;
    logic [1:0]        step;
    op_t               op;
    id_sel_t           sel;
    logic              byte_mode;
    logic              unprot;
    logic              hwrst;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   wdata;
    logic [DQ_W-1:0]   rdata;
    logic              need_rst;
    logic              refused;
    logic              prot;
    logic              tmo;
    logic [31:0]       prdata;
    logic              pslverr;
  } seq_t;

endpackage : flash_host_pkg

/* File: test/flash_dev_model.sv */
// Behavioural parallel NOR flash: array read, unlock and identifier commands, high-level id.
// Assumes host strobes from one registered controller; the device itself has no clock.
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MAKER     = 8'h3C,  // Arbitrary maker code
  parameter logic [7:0] DEV_LO    = 8'hA7,  // Arbitrary device code, low byte
  parameter logic [7:0] DEV_HI    = 8'h5E,  // Arbitrary device code, high byte
  parameter logic [3:0] PROT_SECT = 4'hF    // Protected sector on the top address bits
)(
  // Host pins
  input  wire logic [15:0] i_dq,
  input  wire logic        i_dq_oe,
  input  wire logic [18:0] i_addr,
  input  wire logic        i_am1,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_byte_n,
  input  wire logic        i_reset_n,
  input  wire logic        i_idv_hv,
  // Data back to the host
  output logic [15:0]      o_dq
);
  typedef enum logic [1:0] {M_ARRAY, M_UNL1, M_UNL2, M_ID} mode_t;
  mode_t       mode   = M_ARRAY;  // Array read from power-up
  logic [19:0] wa_q   = '0;       // Latched write address
  logic [15:0] rv;                // Value the read path would show
  logic [15:0] last   = '0;       // Last value driven, inverted once released
  time         fall_t = 0;        // Strobe fall time for pulse width
  int          viol   = 0;        // Count of host strobe faults
  wire         wstrb  = i_ce_n | i_we_n;
  wire  [19:0] wa     = i_byte_n ? {1'b0, i_addr} : {i_addr, i_am1};
  wire  [19:0] u1     = i_byte_n ? 20'h00555 : 20'h00AAA;
  wire  [19:0] u2     = i_byte_n ? 20'h002AA : 20'h00555;
  // Address taken at the later falling strobe
  always @(negedge wstrb)
  begin
    wa_q = wa;
    fall_t = $time;
    if (i_oe_n === 1'b0) viol++;
  end
  // Output enable falling inside a write is a fault
  always @(negedge i_oe_n) if (wstrb === 1'b0) viol++;
  // Command decode on the earlier rising strobe
  always @(posedge wstrb or negedge i_reset_n)
    if (!i_reset_n) mode = M_ARRAY;
    else if (i_oe_n === 1'b1 && i_dq_oe === 1'b1)
    begin
      if ($time - fall_t < 5) viol++;
      else if (i_dq[7:0] == 8'hF0) mode = M_ARRAY;
      else
        case (mode)
          M_ARRAY: mode = (wa_q == u1 && i_dq[7:0] == 8'hAA) ? M_UNL1 : M_ARRAY;
          M_UNL1:  mode = (wa_q == u2 && i_dq[7:0] == 8'h55) ? M_UNL2 : M_ARRAY;
          M_UNL2:  mode = (wa_q == u1 && i_dq[7:0] == 8'h90) ? M_ID : M_ARRAY;
          default: ;  // Only the reset command or the reset pin leaves id mode
        endcase
    end
  // Read value: identifier codes or an address-derived array pattern
  always_comb
    if (i_idv_hv || mode == M_ID)
      case (i_addr[1:0])
        2'h0:    rv = {8'h00, MAKER};
        2'h1:    rv = {i_byte_n ? DEV_HI : 8'h00, DEV_LO};
        2'h2:    rv = {15'h0, i_addr[18:15] == PROT_SECT};
        default: rv = 16'h0000;
      endcase
    else rv = i_byte_n ? {wa[7:0], ~wa[7:0]} : {8'h00, ~wa[7:0]};
  // Keep the last driven value so a released bus shows its inverse
  always @(posedge i_oe_n or posedge i_ce_n) last = rv;
  assign o_dq = (!i_ce_n && !i_oe_n && i_reset_n) ? rv : ~last;
endmodule : flash_dev_model
`default_nettype wire

/* File: test/tb_top.sv */
// Testbench for the flash host: APB sequences against the flash model, with expected values.
// Assumes the register map, op codes and zero-wait APB of the controller package.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("ERROR t=%0t got %0h exp %0h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  import flash_host_pkg::*;
  localparam logic [7:0] MK = 8'h3C;  // Arbitrary maker code
  localparam logic [7:0] DL = 8'hA7;  // Arbitrary device code, low byte
  localparam logic [7:0] DH = 8'h5E;  // Arbitrary device code, high byte
  logic I_CLK = 0, I_NRST = 0, psel = 0, penable = 0, pwrite = 0, byte_m = 0, se;
  logic [7:0]  paddr  = '0;
  logic [31:0] pwdata = '0, rv;
  logic [15:0] exp_id [3];
  wire logic [31:0] prdata;
  wire logic [15:0] dq_in, dq_out;
  wire logic [18:0] fa;
  wire logic pready, pslverr, dq_oe, am1, ce_n, oe_n, we_n, byte_n, rst_n, idvhv, rsthv;
  int err_count = 0, samples_checked = 0;

  flash_host dut (.I_CLK(I_CLK), .I_NRST(I_NRST), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .I_FL_DQ(dq_in), .O_FL_DQ(dq_out), .O_FL_DQ_OE(dq_oe),
    .O_FL_ADDR(fa), .O_FL_AM1(am1), .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n), .O_FL_WE_N(we_n),
    .O_FL_BYTE_N(byte_n), .O_FL_RESET_N(rst_n), .O_FL_IDV_HV(idvhv), .O_FL_RST_HV(rsthv));
  flash_dev_model #(.MAKER(MK), .DEV_LO(DL), .DEV_HI(DH), .PROT_SECT(4'hF)) flash (
    .i_dq(dq_out), .i_dq_oe(dq_oe), .i_addr(fa), .i_am1(am1), .i_ce_n(ce_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_byte_n(byte_n), .i_reset_n(rst_n),
    .i_idv_hv(idvhv), .o_dq(dq_in));

  // Clock
  initial forever #20 I_CLK = ~I_CLK;

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge I_CLK);
    penable <= 1'b1;
    @(posedge I_CLK);
    while (pready !== 1'b1) @(posedge I_CLK);
    rv = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Start an operation and wait until the controller is idle
  task automatic run(input logic [2:0] op, input logic [1:0] sel);
    int n;
    n = 0;
    apb(1'b1, REG_CTRL, {23'h0, 1'b0, 1'b1, 1'b0, byte_m, sel, op});
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    while (rv[STAT_BUSY_BIT] !== 1'b0 && n < 50);
    `CHK(rv[STAT_BUSY_BIT], 1'b0);
  endtask : run

  // Read at an address and leave the result in rv
  task automatic rd_at(input logic [19:0] a);
    apb(1'b1, REG_ADDR, {12'h0, a});
    run(OP_READ, 2'h0);
    apb(1'b0, REG_RDATA, 32'h0);
  endtask : rd_at

  // One raw flash write cycle
  task automatic wcmd(input logic [19:0] a, input logic [15:0] d);
    apb(1'b1, REG_ADDR, {12'h0, a});
    apb(1'b1, REG_WDATA, {16'h0, d});
    run(OP_WRITE, 2'h0);
  endtask : wcmd

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge I_CLK);
    err_count++;
    end_sim();
  end

  // Test sequence
  initial
  begin
    exp_id = '{{8'h00, MK}, {DH, DL}, 16'h0001};
    repeat (16) @(posedge I_CLK);
    I_NRST <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rv, 32'h0);
    apb(1'b1, REG_RDATA, 32'hFFFF);
    apb(1'b0, REG_RDATA, 32'h0);
    `CHK(rv, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    `CHK({se, rv}, 33'h100000000);
    $display("test registers done");
    rd_at(20'h00123);
    `CHK(rv, 32'h000023DC);
    apb(1'b1, REG_ADDR, 32'h78000);
    for (int s = 0; s < 3; s++)
    begin
      run(OP_HVID, 2'(s));
      apb(1'b0, REG_RDATA, 32'h0);
      `CHK(rv, {16'h0, exp_id[s]});
    end
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rv[STAT_PROT_BIT], 1'b1);
    apb(1'b1, REG_ADDR, 32'h08000);
    run(OP_HVID, 2'h2);
    apb(1'b0, REG_RDATA, 32'h0);
    `CHK(rv, 32'h0);
    $display("test high level identifier done");
    apb(1'b1, REG_ADDR, 32'h78000);
    run(OP_AUTOSEL, 2'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rv[STAT_NEEDRST_BIT], 1'b1);
    for (int s = 0; s < 3; s++)
    begin
      run(OP_IDREAD, 2'(s));
      apb(1'b0, REG_RDATA, 32'h0);
      `CHK(rv, {16'h0, exp_id[s]});
    end
    run(OP_READ, 2'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rv[STAT_REFUSED_BIT], 1'b1);
    run(OP_RESET, 2'h0);
    rd_at(20'h00123);
    `CHK(rv, 32'h000023DC);
    $display("test command identifier done");
    byte_m = 1'b1;
    apb(1'b1, REG_ADDR, 32'hF0000);
    run(OP_AUTOSEL, 2'h0);
    run(OP_IDREAD, 2'h1);
    apb(1'b0, REG_RDATA, 32'h0);
    `CHK(rv[7:0], DL);
    run(OP_IDREAD, 2'h2);
    apb(1'b0, REG_RDATA, 32'h0);
    `CHK(rv[7:0], 8'h01);
    run(OP_RESET, 2'h0);
    rd_at(20'h00247);
    `CHK(rv[7:0], 8'hB8);
    byte_m = 1'b0;
    $display("test byte mode done");
    apb(1'b1, REG_ADDR, 32'h00010);
    run(OP_POLL, 2'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK({rv[STAT_TMO_BIT], rv[STAT_NEEDRST_BIT]}, 2'b11);
    rd_at(20'h00123);
    `CHK(rv, 32'h000010EF);
    run(OP_RESET, 2'h0);
    rd_at(20'h00123);
    `CHK(rv, 32'h000023DC);
    $display("test timeout poll done");
    wcmd(20'h00555, 16'h00AA);
    wcmd(20'h002AA, 16'h0055);
    wcmd(20'h00555, 16'h0033);
    rd_at(20'h00000);
    `CHK(rv, 32'h000000FF);
    wcmd(20'h00555, 16'h00AA);
    wcmd(20'h002AA, 16'h0055);
    wcmd(20'h00555, 16'h0090);
    rd_at(20'h00000);
    `CHK(rv, {24'h0, MK});
    wcmd(20'h12345, 16'h00F0);
    rd_at(20'h00000);
    `CHK(rv, 32'h000000FF);
    $display("test raw writes done");
    run(OP_AUTOSEL, 2'h0);
    apb(1'b1, REG_CTRL, 32'h100);
    apb(1'b1, REG_CTRL, 32'h0);
    rd_at(20'h00123);
    `CHK(rv, 32'h000023DC);
    apb(1'b1, REG_CTRL, 32'h40);
    repeat (2) @(posedge I_CLK);
    `CHK(rsthv, 1'b1);
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (2) @(posedge I_CLK);
    `CHK(rsthv, 1'b0);
    `CHK(flash.viol, 0);
    $display("test pins done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
